// >>> fbio_pkg.sv
// fbio_pkg: constants and types for the ring-fieldbus remote I/O core.
// assumes a 25 MHz system clock and one process word per bus cycle.
package fbio_pkg;

	// channel counts and grouping
	localparam int NUM_IN = 12;
	localparam int NUM_OUT = 4;
	localparam int GROUP_SIZE = 4;
	localparam int NUM_GROUPS = 3;

	// input word layout: channels 7..0 high byte, 11..8 low nibble
	localparam int IN_LO_CH_POS = 8;
	localparam int IN_HI_CH_POS = 0;
	localparam int IN_UNUSED_POS = 4;
	localparam logic [3:0] IN_UNUSED_VAL = 4'h0;
	localparam int THERMO_CH = 11;

	// output word layout: outputs 0..3 at word bits 10..13
	localparam int OUT_POS = 10;

	// identification: length code names one process data word
	localparam logic [7:0] LEN_CODE_VAL = 8'h01;
	localparam logic [7:0] ID_CODE_DEFAULT = 8'hA5; // arbitrary value

	// reset values
	localparam logic [15:0] IN_WORD_RST = 16'h0000;
	localparam logic [3:0] OUT_RST = 4'h0;

	// indicator flash timing
	localparam int CLK_HZ = 25_000_000;
	localparam int FLASH_HALF_MS = 250;
	localparam int FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;

	// registered state of the core
	typedef struct packed {
		logic [15:0] in_word;
		logic [3:0] out_drv;
		logic armed;
		logic [11:0] in_yel;
		logic [11:0] in_red;
		logic [3:0] out_yel;
		logic [3:0] out_red;
		logic err;
		logic diag;
		logic link_in;
		logic link_out;
		logic logic_led;
		logic act_led;
	} fbio_state_s;

endpackage

// >>> fbio_flash_if.sv
// fbio_flash_if: flash pattern levels from the blink divider to the core.
// assumes both ends share the single system clock.
`timescale 1ns/100ps
`default_nettype none
interface fbio_flash_if;
	logic fast; // toggles every flash half period
	logic slow; // toggles every second half period

	modport src (output fast, output slow);
	modport snk (input fast, input slow);
endinterface
`default_nettype wire

// >>> fbio_blink.sv
// fbio_blink: divider making the two indicator flash patterns.
// assumes one clock; the half period is shortened for simulation.
`timescale 1ns/100ps
`default_nettype none
module fbio_blink
	import fbio_pkg::*;
#(
	parameter int HALF_CYC = FLASH_HALF_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	fbio_flash_if.src flash
);
	localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
	localparam logic [CW-1:0] CNT_TOP = CW'(HALF_CYC - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic fast;
		logic slow;
	} fbio_blink_s;

	fbio_blink_s s;
	fbio_blink_s next_s;
	logic tick;

	// one-cycle enable at the end of each half period
	always_comb begin
		next_s = s;
		tick = (s.cnt == CNT_TOP);
		if (tick) begin
			next_s.cnt = '0;
			next_s.fast = ~s.fast;
			// slow pattern halves the fast one
			if (s.fast)
				next_s.slow = ~s.slow;
		end else begin
			next_s.cnt = s.cnt + CW'(1);
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign flash.fast = s.fast;
	assign flash.slow = s.slow;

	a_fast_toggle: assert property (@(posedge clk) disable iff (!rst_n)
		tick |=> flash.fast != $past(flash.fast))
		else $error("fast flash did not toggle on tick");

endmodule // fbio_blink
`default_nettype wire

// >>> fbio_core.sv
// fbio_core: process image and indicator logic of a 12-in/4-out I/O node.
// assumes the bus controller delivers one word per cycle with a strobe.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - one 16-bit word each way per bus cycle, no parameter channel.
// - inputs 7..0 on bits 15..8, 11..8 on bits 3..0, 7..4 unused.
// - outputs 0..3 from word bits 10..13, other bits ignored.
// - variant with thermostat takes channel 11 only from the thermostat input.
// - diag indicator steady only with supply, bus active, no I/O error.
// - incoming link indicator on while incoming connection is good.
// - outgoing link indicator on while outgoing segment is disabled.
// - error indicator on while any supply group or output is faulted.
// - logic supply indicator steady, flashing on undervoltage, dark if absent.
// - actuator supply indicator steady if in range, else flashing.
// - input indicator yellow when set, dark when clear, supply healthy.
// - faulted sensor group turns its four input indicators red.
// - inputs form three groups of four, each with its own fault flag.
// - output indicator yellow when set, dark when clear, without fault.
// - output indicator red while that output is faulted.
// - welding regulation and monitor lines pass straight through.
module fbio_core
	import fbio_pkg::*;
#(
	parameter logic [7:0] ID_CODE_VAL = ID_CODE_DEFAULT, // arbitrary value
	parameter int FLASH_CYC = FLASH_HALF_CYC,
	parameter bit SF_VARIANT = 1'b0
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RSTN,
	// process data exchange
	input wire logic BUS_CYCLE,
	input wire logic [15:0] OUT_WORD,
	output logic [15:0] IN_WORD,
	output logic [7:0] ID_CODE,
	output logic [7:0] LEN_CODE,
	// field inputs and outputs
	input wire logic [11:0] SENSOR_IN,
	input wire logic THERMO_SWITCH,
	output logic [3:0] OUT_DRV,
	// supply, link and fault status
	input wire logic LOGIC_SUPPLY_PRESENT,
	input wire logic LOGIC_SUPPLY_LOW,
	input wire logic ACT_SUPPLY_OK,
	input wire logic BUS_ACTIVE,
	input wire logic LINK_IN_OK,
	input wire logic OUT_SEG_DISABLED,
	input wire logic [2:0] SENSOR_GRP_FAULT,
	input wire logic [3:0] OUTPUT_FAULT,
	// front panel indicators
	output logic BUS_DIAG_LED,
	output logic INCOMING_LINK_LED,
	output logic OUTGOING_LINK_LED,
	output logic ERROR_LED,
	output logic LOGIC_SUPPLY_LED,
	output logic ACT_SUPPLY_LED,
	output logic [11:0] IN_LED_YEL,
	output logic [11:0] IN_LED_RED,
	output logic [3:0] OUT_LED_YEL,
	output logic [3:0] OUT_LED_RED,
	// welding pass-through lines
	input wire logic [1:0] WELD_CURRENT_REG_IN,
	input wire logic [1:0] SEC_CIRCUIT_MON_IN,
	output logic [1:0] WELD_CURRENT_REG_OUT,
	output logic [1:0] SEC_CIRCUIT_MON_OUT
);

	// spread group fault flags over their channels
	function automatic logic [11:0] expand_groups(input logic [2:0] g);
		logic [11:0] r;
		r = '0;
		for (int i = 0; i < NUM_IN; i++)
			r[i] = g[i / GROUP_SIZE];
		return r;
	endfunction

	fbio_state_s s;
	fbio_state_s next_s;
	logic [11:0] chan;
	logic [11:0] grp_red;
	logic io_error;

	fbio_flash_if flash ();

	// flash patterns come from a shared divider
	fbio_blink #(
		.HALF_CYC(FLASH_CYC)
	) u_blink (
		.clk(CLK),
		.rst_n(RSTN),
		.flash(flash)
	);

	// channel source selection
	always_comb begin
		chan = SENSOR_IN;
		if (SF_VARIANT)
			chan[THERMO_CH] = THERMO_SWITCH;
	end

	assign grp_red = expand_groups(SENSOR_GRP_FAULT);
	// any short or overload counts as an I/O error
	assign io_error = (|SENSOR_GRP_FAULT) | (|OUTPUT_FAULT);

	// next state of process image and indicators
	always_comb begin
		next_s = s;
		if (BUS_CYCLE) begin
			next_s.in_word[IN_LO_CH_POS +: 8] = chan[7:0];
			next_s.in_word[IN_HI_CH_POS +: 4] = chan[11:8];
			next_s.in_word[IN_UNUSED_POS +: 4] = IN_UNUSED_VAL;
			next_s.out_drv = OUT_WORD[OUT_POS +: NUM_OUT];
			next_s.armed = 1'b1;
		end
		if (!next_s.armed)
			next_s.out_drv = OUT_RST;

		if (!LOGIC_SUPPLY_PRESENT)
			next_s.diag = 1'b0;
		else if (!BUS_ACTIVE)
			next_s.diag = flash.slow;
		else if (io_error)
			next_s.diag = flash.fast;
		else
			next_s.diag = 1'b1;

		next_s.link_in = LINK_IN_OK;
		next_s.link_out = OUT_SEG_DISABLED;
		next_s.err = io_error;

		if (!LOGIC_SUPPLY_PRESENT)
			next_s.logic_led = 1'b0;
		else if (LOGIC_SUPPLY_LOW)
			next_s.logic_led = flash.fast;
		else
			next_s.logic_led = 1'b1;

		next_s.act_led = ACT_SUPPLY_OK ? 1'b1 : flash.fast;

		next_s.in_yel = chan & ~grp_red & {NUM_IN{LOGIC_SUPPLY_PRESENT}};
		next_s.in_red = grp_red;

		next_s.out_yel = next_s.out_drv & ~OUTPUT_FAULT;
		next_s.out_red = OUTPUT_FAULT;
	end

	// single state register
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			s <= '0;
			s.in_word <= IN_WORD_RST;
			s.out_drv <= OUT_RST;
		end else begin
			s <= next_s;
		end
	end

	// registered outputs
	assign IN_WORD = s.in_word;
	assign OUT_DRV = s.out_drv;
	assign BUS_DIAG_LED = s.diag;
	assign INCOMING_LINK_LED = s.link_in;
	assign OUTGOING_LINK_LED = s.link_out;
	assign ERROR_LED = s.err;
	assign LOGIC_SUPPLY_LED = s.logic_led;
	assign ACT_SUPPLY_LED = s.act_led;
	assign IN_LED_YEL = s.in_yel;
	assign IN_LED_RED = s.in_red;
	assign OUT_LED_YEL = s.out_yel;
	assign OUT_LED_RED = s.out_red;

	assign ID_CODE = ID_CODE_VAL;
	assign LEN_CODE = LEN_CODE_VAL;

	// straight pass-through
	// no flop here: the welding controller owns the timing of these lines
	assign WELD_CURRENT_REG_OUT = WELD_CURRENT_REG_IN;
	assign SEC_CIRCUIT_MON_OUT = SEC_CIRCUIT_MON_IN;

	// checks on the process image and indicators
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RSTN);

	a_in_word_map: assert property (
		BUS_CYCLE |=> IN_WORD[15:8] == $past(chan[7:0])
			&& IN_WORD[3:0] == $past(chan[11:8])
			&& IN_WORD[7:4] == 4'h0)
		else $error("input word packing wrong");

	a_out_bit_pick: assert property (
		BUS_CYCLE |=> OUT_DRV == $past(OUT_WORD[13:10]))
		else $error("outputs not taken from bits 13..10");

	a_word_held: assert property (
		!BUS_CYCLE |=> $stable(IN_WORD) && $stable(OUT_DRV))
		else $error("process word changed outside a bus cycle");

	a_thermo_chan: assert property (
		BUS_CYCLE |=> IN_WORD[3] ==
			$past(SF_VARIANT ? THERMO_SWITCH : SENSOR_IN[11]))
		else $error("channel 11 from wrong source");

	a_diag_steady: assert property (
		(LOGIC_SUPPLY_PRESENT && BUS_ACTIVE && !io_error) |=> BUS_DIAG_LED)
		else $error("diag not steady when healthy");

	a_diag_dark: assert property (
		!LOGIC_SUPPLY_PRESENT |=> !BUS_DIAG_LED)
		else $error("diag lit without supply");

	a_link_state: assert property (
		##1 INCOMING_LINK_LED == $past(LINK_IN_OK)
			&& OUTGOING_LINK_LED == $past(OUT_SEG_DISABLED))
		else $error("link indicators do not follow state");

	a_error_group: assert property (
		##1 ERROR_LED == $past(|SENSOR_GRP_FAULT || |OUTPUT_FAULT))
		else $error("error indicator wrong");

	a_logic_led: assert property (
		(LOGIC_SUPPLY_PRESENT && !LOGIC_SUPPLY_LOW) |=> LOGIC_SUPPLY_LED)
		else $error("logic supply indicator not steady");

	a_act_led: assert property (
		ACT_SUPPLY_OK |=> ACT_SUPPLY_LED)
		else $error("actuator supply indicator not steady");

	a_group_red: assert property (
		SENSOR_GRP_FAULT[1] |=> IN_LED_RED[7:4] == 4'hF
			&& IN_LED_YEL[7:4] == 4'h0)
		else $error("faulted group not all red");

	a_out_red: assert property (
		OUTPUT_FAULT[2] |=> OUT_LED_RED[2] && !OUT_LED_YEL[2])
		else $error("faulted output not red");

	a_out_yel: assert property (
		##1 (!$past(OUTPUT_FAULT[0])) |-> OUT_LED_YEL[0] == OUT_DRV[0])
		else $error("output indicator not following output");

	a_outs_off: assert property (
		!s.armed |-> OUT_DRV == 4'h0)
		else $error("outputs driven before first word");

	a_pass_thru: assert property (
		WELD_CURRENT_REG_OUT == WELD_CURRENT_REG_IN
			&& SEC_CIRCUIT_MON_OUT == SEC_CIRCUIT_MON_IN)
		else $error("welding lines altered");

	a_diag_slow: assert property (
		(LOGIC_SUPPLY_PRESENT && !BUS_ACTIVE)
			|=> BUS_DIAG_LED == $past(flash.slow))
		else $error("diag not slow flashing with bus idle");

	a_diag_fast: assert property (
		(LOGIC_SUPPLY_PRESENT && BUS_ACTIVE && io_error)
			|=> BUS_DIAG_LED == $past(flash.fast))
		else $error("diag not fast flashing on io error");

	a_logic_dark: assert property (
		!LOGIC_SUPPLY_PRESENT |=> !LOGIC_SUPPLY_LED)
		else $error("logic supply indicator lit without supply");

	a_logic_flash: assert property (
		(LOGIC_SUPPLY_PRESENT && LOGIC_SUPPLY_LOW)
			|=> LOGIC_SUPPLY_LED == $past(flash.fast))
		else $error("logic supply indicator not flashing when low");

	a_act_flash: assert property (
		!ACT_SUPPLY_OK |=> ACT_SUPPLY_LED == $past(flash.fast))
		else $error("actuator supply indicator not flashing");

	a_in_yel_grp: assert property (
		(LOGIC_SUPPLY_PRESENT && !SENSOR_GRP_FAULT[0])
			|=> IN_LED_YEL[3:0] == $past(chan[3:0]))
		else $error("input indicators do not follow inputs");

	a_in_dark: assert property (
		!LOGIC_SUPPLY_PRESENT |=> IN_LED_YEL == 12'h000)
		else $error("input indicators lit without supply");

	a_grp_clear: assert property (
		!SENSOR_GRP_FAULT[2] |=> IN_LED_RED[11:8] == 4'h0)
		else $error("healthy group shows red");

	c_first_word: cover property (!s.armed ##1 BUS_CYCLE ##1 s.armed);
	c_group_fault: cover property (SENSOR_GRP_FAULT == 3'h1 ##1 ERROR_LED);
	c_diag_flash: cover property (BUS_ACTIVE && io_error
		&& LOGIC_SUPPLY_PRESENT ##1 !BUS_DIAG_LED);
	c_out_fault: cover property (OUTPUT_FAULT != 4'h0 ##1 OUT_LED_RED != 4'h0);
	c_supply_low: cover property (LOGIC_SUPPLY_PRESENT && LOGIC_SUPPLY_LOW
		##1 LOGIC_SUPPLY_LED ##1 !LOGIC_SUPPLY_LED);

endmodule // fbio_core
`default_nettype wire

// >>> fbio_master_model.sv
// fbio_master_model: bus master side trading one process word per cycle.
// assumes the node takes the word on the CLK edge with BUS_CYCLE high.
`timescale 1ns/100ps
`default_nettype none
module fbio_master_model (
	// clock
	input wire logic CLK,
	// process exchange
	output logic BUS_CYCLE,
	output logic [15:0] OUT_WORD,
	input wire logic [15:0] IN_WORD
);
	// idle lines: all-ones data so a stray take would show
	initial begin
		BUS_CYCLE = 1'b0;
		OUT_WORD = 16'hFFFF;
	end

	task automatic xfer(input logic [15:0] w, output logic [15:0] rd);
		@(posedge CLK);
		#1;
		BUS_CYCLE = 1'b1;
		OUT_WORD = w;
		@(posedge CLK);
		#1;
		BUS_CYCLE = 1'b0;
		OUT_WORD = ~w; // stale data must never look valid
		rd = IN_WORD;
	endtask
endmodule // fbio_master_model
`default_nettype wire

// >>> tb.sv
// tb: self-checking bench for the remote I/O core, thermostat variant.
// assumes a shortened flash half period of 4 cycles.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import fbio_pkg::*;
	localparam logic [7:0] ID_VAL = 8'h5A; // arbitrary value
	logic CLK = 1'b0, RSTN = 1'b0, BUS_CYCLE, THERMO_SWITCH = 1'b0;
	logic [15:0] OUT_WORD, IN_WORD;
	logic [11:0] SENSOR_IN = 12'h000, IN_LED_YEL, IN_LED_RED;
	logic LOGIC_SUPPLY_PRESENT = 1'b0, LOGIC_SUPPLY_LOW = 1'b0;
	logic ACT_SUPPLY_OK = 1'b1, BUS_ACTIVE = 1'b1, LINK_IN_OK = 1'b0;
	logic OUT_SEG_DISABLED = 1'b0;
	logic [2:0] SENSOR_GRP_FAULT = 3'h0;
	logic [3:0] OUTPUT_FAULT = 4'h0, OUT_DRV, OUT_LED_YEL, OUT_LED_RED;
	logic [7:0] ID_CODE, LEN_CODE;
	logic BUS_DIAG_LED, INCOMING_LINK_LED, OUTGOING_LINK_LED, ERROR_LED;
	logic LOGIC_SUPPLY_LED, ACT_SUPPLY_LED;
	logic [1:0] WELD_CURRENT_REG_IN = 2'h0, SEC_CIRCUIT_MON_IN = 2'h0;
	logic [1:0] WELD_CURRENT_REG_OUT, SEC_CIRCUIT_MON_OUT;
	logic [15:0] owt [4] = '{16'h2400, 16'hC3FF, 16'h3C00, 16'h1234};
	int fail_count = 0;
	int n_checks = 0;

	// core and bus master
	fbio_core #(.ID_CODE_VAL(ID_VAL), .FLASH_CYC(4), .SF_VARIANT(1'b1)) dut_u (
		.CLK, .RSTN, .BUS_CYCLE, .OUT_WORD, .IN_WORD, .ID_CODE, .LEN_CODE,
		.SENSOR_IN, .THERMO_SWITCH, .OUT_DRV, .LOGIC_SUPPLY_PRESENT,
		.LOGIC_SUPPLY_LOW, .ACT_SUPPLY_OK, .BUS_ACTIVE, .LINK_IN_OK,
		.OUT_SEG_DISABLED, .SENSOR_GRP_FAULT, .OUTPUT_FAULT, .BUS_DIAG_LED,
		.INCOMING_LINK_LED, .OUTGOING_LINK_LED, .ERROR_LED, .LOGIC_SUPPLY_LED,
		.ACT_SUPPLY_LED, .IN_LED_YEL, .IN_LED_RED, .OUT_LED_YEL, .OUT_LED_RED,
		.WELD_CURRENT_REG_IN, .SEC_CIRCUIT_MON_IN, .WELD_CURRENT_REG_OUT,
		.SEC_CIRCUIT_MON_OUT);
	fbio_master_model mst_u (.CLK, .BUS_CYCLE, .OUT_WORD, .IN_WORD);

	// 25 MHz clock
	always #20 CLK = ~CLK;

	task automatic chk(input string nm, input logic [15:0] e,
			input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// inputs change 1 ns after the edge, outputs read there too
	task automatic tick(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask

	// k: 0 dark, 1 steady, 2 fast flash, 3 slow flash over 32 cycles
	task automatic pat(input string nm, input int sel, input int k);
		int on, tg;
		logic v, p;
		on = 0;
		tg = 0;
		p = 1'b0;
		for (int i = 0; i < 32; i++) begin
			tick(1);
			v = sel == 0 ? BUS_DIAG_LED
				: sel == 1 ? LOGIC_SUPPLY_LED : ACT_SUPPLY_LED;
			on += (v === 1'b1);
			if (i > 0 && v !== p)
				tg++;
			p = v;
		end
		n_checks++;
		if (k == 0 ? on != 0 : k == 1 ? on != 32
				: k == 2 ? tg < 6 : tg < 3 || tg > 5) begin
			fail_count++;
			$display("[FAIL] %s expected pattern %0d seen on %0d toggles %0d",
				nm, k, on, tg);
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// hang guard
	initial begin
		#200000;
		fail_count++;
		final_report();
	end

	// main sequence
	initial begin
		logic [15:0] rd;
		logic [11:0] m;
		logic [15:0] e;
		tick(3);
		RSTN = 1'b1;
		tick(4);
		chk("out_drv", 16'h0000, OUT_DRV);
		chk("id_code", ID_VAL, ID_CODE);
		chk("len_code", LEN_CODE_VAL, LEN_CODE);
		$display("test reset done");
		// thermostat replaces channel 11 whatever the connector shows
		for (int k = 0; k < 4; k++) begin
			SENSOR_IN = k[0] ? 12'h75A : 12'h8A5;
			THERMO_SWITCH = k[1];
			mst_u.xfer(16'h0000, rd);
			e = {SENSOR_IN[7:0], 4'h0, THERMO_SWITCH, SENSOR_IN[10:8]};
			chk("in_word", e, rd);
		end
		$display("test input word done");
		for (int i = 0; i < 4; i++) begin
			mst_u.xfer(owt[i], rd);
			chk("out_drv", owt[i][13:10], OUT_DRV);
			OUTPUT_FAULT = 4'(i * 5);
			tick(1);
			chk("out_yel", owt[i][13:10] & ~OUTPUT_FAULT, OUT_LED_YEL);
			chk("out_red", OUTPUT_FAULT, OUT_LED_RED);
			chk("err_led", |OUTPUT_FAULT, ERROR_LED);
		end
		OUTPUT_FAULT = 4'h0;
		$display("test outputs done");
		// reset in mid run must drop the outputs until the next word
		RSTN = 1'b0;
		tick(1);
		RSTN = 1'b1;
		tick(2);
		chk("out_drv_rst", 16'h0000, OUT_DRV);
		mst_u.xfer(owt[2], rd);
		chk("out_drv_rearm", owt[2][13:10], OUT_DRV);
		$display("test reset in run done");
		LOGIC_SUPPLY_PRESENT = 1'b1;
		THERMO_SWITCH = 1'b0;
		SENSOR_IN = 12'h5C6;
		for (int g = 0; g < 4; g++) begin
			SENSOR_GRP_FAULT = g == 3 ? 3'h0 : 3'(1 << g);
			tick(1);
			m = {{4{SENSOR_GRP_FAULT[2]}}, {4{SENSOR_GRP_FAULT[1]}},
				{4{SENSOR_GRP_FAULT[0]}}};
			chk("in_red", m, IN_LED_RED);
			chk("in_yel", SENSOR_IN & ~m, IN_LED_YEL);
			chk("err_led", |SENSOR_GRP_FAULT, ERROR_LED);
		end
		$display("test input leds done");
		for (int k = 0; k < 4; k++) begin
			{LINK_IN_OK, OUT_SEG_DISABLED} = 2'(k);
			WELD_CURRENT_REG_IN = 2'(k);
			SEC_CIRCUIT_MON_IN = ~2'(k);
			tick(1);
			chk("link_in", LINK_IN_OK, INCOMING_LINK_LED);
			chk("link_out", OUT_SEG_DISABLED, OUTGOING_LINK_LED);
			chk("weld", WELD_CURRENT_REG_IN, WELD_CURRENT_REG_OUT);
			chk("mon", SEC_CIRCUIT_MON_IN, SEC_CIRCUIT_MON_OUT);
		end
		$display("test links done");
		pat("diag", 0, 1);
		pat("logic_led", 1, 1);
		pat("act_led", 2, 1);
		SENSOR_GRP_FAULT = 3'h4;
		pat("diag", 0, 2);
		SENSOR_GRP_FAULT = 3'h0;
		BUS_ACTIVE = 1'b0;
		pat("diag", 0, 3);
		LOGIC_SUPPLY_LOW = 1'b1;
		ACT_SUPPLY_OK = 1'b0;
		pat("logic_led", 1, 2);
		pat("act_led", 2, 2);
		LOGIC_SUPPLY_PRESENT = 1'b0;
		pat("diag", 0, 0);
		pat("logic_led", 1, 0);
		$display("test flash patterns done");
		final_report();
	end
endmodule // tb
`default_nettype wire
